// *** bench/pa_assembler_checker.sv ***
// Port-level assertions for the primitive assembler
`timescale 1ns/1ps
module pa_assembler_checker #(
  parameter int VW        = 32,
  parameter int MAX_PATCH = 32
) (
  input wire logic             ref_clk_in,
  input wire logic             rst_in,
  input wire logic             in_valid_in,
  input wire logic             in_ready_out,
  input wire logic             in_first_in,
  input wire pa_pkg::pa_mode_t mode_in,
  input wire logic             gs_active_in,
  input wire logic             cfg_valid_in,
  input wire logic [15:0]      cfg_pname_in,
  input wire logic [31:0]      cfg_value_in,
  input wire logic [7:0]       patch_size_out,
  input wire logic             err_enum_out,
  input wire logic             err_value_out,
  input wire logic             out_valid_out,
  input wire logic             out_ready_in,
  input wire logic [VW-1:0]    out_vtx_out,
  input wire logic             out_prim_first_out,
  input wire logic             out_prim_last_out,
  input wire logic             out_adj_out
);
  // ==========================================================================
  // Helper state
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  pa_pkg::pa_mode_t mode_reg;
  logic             gs_reg;
  logic [7:0]       val_reg;
  wire sel_ok = cfg_pname_in == pa_pkg::PA_PNAME_PATCH_VTX;
  wire bad_v  = $signed(cfg_value_in) <= 0 || $signed(cfg_value_in) > MAX_PATCH;
  wire take   = in_valid_in && in_ready_out;
  wire adj_md = mode_reg inside {pa_pkg::PA_LINES_ADJ, pa_pkg::PA_LSTRIP_ADJ,
                                 pa_pkg::PA_TRIS_ADJ, pa_pkg::PA_TSTRIP_ADJ};
  always_ff @(posedge ref_clk_in) begin
    val_reg <= cfg_value_in[7:0];
    if (take && in_first_in) begin
      mode_reg <= mode_in;
      gs_reg   <= gs_active_in;
    end
  end

  // ==========================================================================
  // Properties
  property p_enum_err;
    cfg_valid_in && !sel_ok |=> err_enum_out;
  endproperty
  a_enum_err: assert property (p_enum_err) else $error("selector error missing");
  property p_val_err;
    cfg_valid_in && sel_ok && bad_v |=> err_value_out && $stable(patch_size_out);
  endproperty
  a_val_err: assert property (p_val_err) else $error("bad size not refused");
  property p_size_set;
    cfg_valid_in && sel_ok && !bad_v |=> patch_size_out == val_reg && !err_value_out;
  endproperty
  a_size_set: assert property (p_size_set) else $error("patch size not taken");
  property p_no_err;
    !cfg_valid_in |=> !err_enum_out && !err_value_out;
  endproperty
  a_no_err: assert property (p_no_err) else $error("error without config");
  property p_hold;
    out_valid_out && !out_ready_in |=> out_valid_out
      && $stable({out_vtx_out, out_prim_first_out, out_prim_last_out, out_adj_out});
  endproperty
  a_hold: assert property (p_hold) else $error("output changed while stalled");
  property p_take;
    take |=> !in_ready_out;
  endproperty
  a_take: assert property (p_take) else $error("ready stayed high after take");
  property p_point;
    out_valid_out && mode_reg == pa_pkg::PA_POINTS |-> out_prim_first_out && out_prim_last_out;
  endproperty
  a_point: assert property (p_point) else $error("point not single vertex");
  property p_adj;
    out_valid_out && out_adj_out |-> gs_reg && adj_md;
  endproperty
  a_adj: assert property (p_adj) else $error("adjacency vertex not expected");
endmodule : pa_assembler_checker

bind pa_assembler pa_assembler_checker #(.VW(VW), .MAX_PATCH(MAX_PATCH)) u_chk (
  .ref_clk_in, .rst_in, .in_valid_in, .in_ready_out, .in_first_in, .mode_in, .gs_active_in,
  .cfg_valid_in, .cfg_pname_in, .cfg_value_in, .patch_size_out, .err_enum_out, .err_value_out,
  .out_valid_out, .out_ready_in, .out_vtx_out, .out_prim_first_out, .out_prim_last_out,
  .out_adj_out);

// *** bench/pa_sink_model.sv ***
// Downstream stage model: records assembled vertices, may stall
`timescale 1ns/1ps
module pa_sink_model (
  input  wire logic        ref_clk_in,
  input  wire logic        stall_in,
  input  wire logic        valid_in,
  input  wire logic [31:0] vtx_in,
  input  wire logic        first_in,
  input  wire logic        last_in,
  input  wire logic        adj_in,
  output logic             ready_out
);
  logic [34:0] got[$];
  logic        tick_reg = 1'b0;
  // Half-rate ready when stalling, so the buffer fills and refuses
  assign ready_out = stall_in ? tick_reg : 1'b1;
  always @(posedge ref_clk_in) begin
    tick_reg <= ~tick_reg;
    if (valid_in && ready_out) got.push_back({vtx_in, first_in, last_in, adj_in});
  end
endmodule : pa_sink_model

// *** bench/test_primitive_assembler.sv ***
// Self-checking testbench of the primitive assembler
`timescale 1ns/1ps
module test_primitive_assembler;
  // ==========================================================================
  // Signals
  localparam int MP = 8;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             vld = 1'b0;
  logic             fst = 1'b0;
  logic             lst = 1'b0;
  logic             gs = 1'b0;
  logic             cv = 1'b0;
  logic             stall = 1'b0;
  logic [31:0]      vtx = 32'h0;
  logic [31:0]      cval = 32'h0;
  logic [15:0]      cpn = 16'h0;
  pa_pkg::pa_mode_t mode = pa_pkg::PA_POINTS;
  logic             rdy, ee, ev, ov, opf, opl, oa, ordy;
  logic [7:0]       psz;
  logic [31:0]      ovtx;
  logic [34:0]      ex[$];
  int               miscompares = 0;
  int               samples_checked = 0;

  always #10 clk = ~clk;

  pa_assembler #(.VW(32), .MAX_PATCH(MP)) DUT (
    .ref_clk_in(clk), .rst_in(rst), .in_valid_in(vld), .in_ready_out(rdy), .in_vtx_in(vtx),
    .in_first_in(fst), .in_last_in(lst), .mode_in(mode), .gs_active_in(gs),
    .cfg_valid_in(cv), .cfg_pname_in(cpn), .cfg_value_in(cval), .patch_size_out(psz),
    .err_enum_out(ee), .err_value_out(ev), .out_valid_out(ov), .out_ready_in(ordy),
    .out_vtx_out(ovtx), .out_prim_first_out(opf), .out_prim_last_out(opl), .out_adj_out(oa));
  pa_sink_model u_sink (.ref_clk_in(clk), .stall_in(stall), .valid_in(ov), .vtx_in(ovtx),
    .first_in(opf), .last_in(opl), .adj_in(oa), .ready_out(ordy));

  // ==========================================================================
  // Drivers and comparisons
  task automatic dr(input pa_pkg::pa_mode_t m, input logic g, input int n, input int b = 0);
    int w;
    mode = m;
    gs = g;
    for (int i = 1; i <= n; i++) begin
      vtx = 32'(b + i);
      fst = (i == 1);
      lst = (i == n);
      vld = 1'b1;
      w = 0;
      while (rdy !== 1'b1 && w < 200) begin
        @(posedge clk) #1;
        w++;
      end
      if (w >= 200) miscompares++;
      @(posedge clk) #1;
      vld = 1'b0;
      @(posedge clk) #1;
    end
    w = 0;
    // Idle for a stretch means the stalled buffer has drained too
    while (w < 12) begin
      @(posedge clk) #1;
      w = (rdy === 1'b1 && ov === 1'b0) ? w + 1 : 0;
    end
  endtask : dr

  task automatic e(input int v, input bit f, input bit l, input bit a);
    ex.push_back({32'(v), f, l, a});
  endtask : e

  // Triangle with adjacency, emitted as p1, a12, p2, a23, p3, a31
  task automatic tri_adj(input int p1, a1, p2, a2, p3, a3);
    e(p1, 1, 0, 0);
    e(a1, 0, 0, 1);
    e(p2, 0, 0, 0);
    e(a2, 0, 0, 1);
    e(p3, 0, 0, 0);
    e(a3, 0, 1, 1);
  endtask : tri_adj

  task automatic pr(input int n, input int a, input int b = 0, input int c = 0);
    int v[3];
    v = '{a, b, c};
    for (int i = 0; i < n; i++) e(v[i], i == 0, i == n - 1, 1'b0);
  endtask : pr

  task automatic cmp(input string nm, input logic [34:0] x, input logic [34:0] g);
    samples_checked++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp

  task automatic cmp_q(input string nm);
    cmp({nm, " count"}, 35'(ex.size()), 35'(u_sink.got.size()));
    foreach (ex[i]) cmp(nm, ex[i], (i < u_sink.got.size()) ? u_sink.got[i] : 'x);
    ex.delete();
    u_sink.got.delete();
  endtask : cmp_q

  task automatic cfg(input logic [15:0] p, input logic [31:0] v);
    // An edge between pulses keeps the strobe from being lowered and raised at once
    @(posedge clk) #1;
    cpn = p;
    cval = v;
    cv = 1'b1;
    @(posedge clk) #1;
    cv = 1'b0;
  endtask : cfg

  // ==========================================================================
  // Scenarios
  task automatic t_lines;
    dr(pa_pkg::PA_POINTS, 0, 2);
    pr(1, 1);
    pr(1, 2);
    cmp_q("points");
    dr(pa_pkg::PA_LINE_STRIP, 0, 1, 16);
    dr(pa_pkg::PA_LINE_STRIP, 0, 3);
    pr(2, 1, 2);
    pr(2, 2, 3);
    cmp_q("strip");
    stall = 1'b1;
    dr(pa_pkg::PA_LINE_LOOP, 0, 3);
    pr(2, 1, 2);
    pr(2, 2, 3);
    pr(2, 3, 1);
    cmp_q("loop");
    stall = 1'b0;
    dr(pa_pkg::PA_LINES, 0, 5);
    pr(2, 1, 2);
    pr(2, 3, 4);
    cmp_q("lines");
  endtask : t_lines

  task automatic t_tris;
    dr(pa_pkg::PA_TRI_STRIP, 0, 4);
    pr(3, 1, 2, 3);
    pr(3, 3, 2, 4);
    cmp_q("tstrip");
    dr(pa_pkg::PA_TRI_FAN, 0, 4);
    pr(3, 1, 2, 3);
    pr(3, 1, 3, 4);
    cmp_q("fan");
    dr(pa_pkg::PA_TRIS, 0, 5);
    pr(3, 1, 2, 3);
    cmp_q("tris");
  endtask : t_tris

  task automatic t_adj;
    dr(pa_pkg::PA_LINES_ADJ, 1, 4);
    e(1, 1, 0, 1);
    e(2, 0, 0, 0);
    e(3, 0, 0, 0);
    e(4, 0, 1, 1);
    dr(pa_pkg::PA_LINES_ADJ, 0, 5);
    pr(2, 2, 3);
    cmp_q("ladj");
    dr(pa_pkg::PA_LSTRIP_ADJ, 0, 3);
    dr(pa_pkg::PA_LSTRIP_ADJ, 0, 5);
    pr(2, 2, 3);
    pr(2, 3, 4);
    cmp_q("lsadj");
    stall = 1'b1;
    dr(pa_pkg::PA_TRIS_ADJ, 1, 6);
    e(1, 1, 0, 0);
    e(2, 0, 0, 1);
    e(3, 0, 0, 0);
    e(4, 0, 0, 1);
    e(5, 0, 0, 0);
    e(6, 0, 1, 1);
    stall = 1'b0;
    dr(pa_pkg::PA_TRIS_ADJ, 0, 8);
    pr(3, 1, 3, 5);
    cmp_q("tadj");
    dr(pa_pkg::PA_TSTRIP_ADJ, 1, 5);
    dr(pa_pkg::PA_TSTRIP_ADJ, 1, 7);
    e(1, 1, 0, 0);
    e(2, 0, 0, 1);
    e(3, 0, 0, 0);
    e(6, 0, 0, 1);
    e(5, 0, 0, 0);
    e(4, 0, 1, 1);
    dr(pa_pkg::PA_TSTRIP_ADJ, 1, 8);
    tri_adj(1, 2, 3, 7, 5, 4);
    tri_adj(5, 1, 3, 6, 7, 8);
    dr(pa_pkg::PA_TSTRIP_ADJ, 1, 10);
    tri_adj(1, 2, 3, 7, 5, 4);
    tri_adj(5, 1, 3, 6, 7, 9);
    tri_adj(5, 3, 7, 10, 9, 8);
    cmp_q("tsadj");
  endtask : t_adj

  task automatic t_patch;
    cmp("size reset", 35'(psz), 35'h3);
    cfg(16'h0002, 32'h5);
    cmp("selector error", 35'(ee), 35'h1);
    cfg(pa_pkg::PA_PNAME_PATCH_VTX, 32'h0);
    cmp("zero error", 35'(ev), 35'h1);
    cfg(pa_pkg::PA_PNAME_PATCH_VTX, 32'hFFFF_FFFF);
    cmp("negative error", 35'(ev), 35'h1);
    cfg(pa_pkg::PA_PNAME_PATCH_VTX, 32'(MP + 1));
    cmp("over max error", 35'(ev), 35'h1);
    cmp("size kept", 35'(psz), 35'h3);
    cfg(pa_pkg::PA_PNAME_PATCH_VTX, 32'(MP));
    cmp("max size", 35'(psz), 35'(MP));
    cfg(pa_pkg::PA_PNAME_PATCH_VTX, 32'h2);
    dr(pa_pkg::PA_PATCHES, 0, 5);
    pr(2, 1, 2);
    pr(2, 3, 4);
    cmp_q("patches");
  endtask : t_patch

  // ==========================================================================
  // Run control
  task automatic conclude;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    t_patch();
    t_lines();
    t_tris();
    t_adj();
    conclude();
  end

  // Whole run needs about 600 cycles; this allows about 20000
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule : test_primitive_assembler

// *** rtl/pa_assembler.sv ***
// Primitive assembler: groups a draw's vertex stream into primitives
`timescale 1ns/1ps
module pa_assembler #(
  parameter int VW        = 32,
  parameter int MAX_PATCH = pa_pkg::PA_MAX_PATCH_DEF
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              in_valid_in,
  output logic                   in_ready_out,
  input  wire logic [VW-1:0]     in_vtx_in,
  input  wire logic              in_first_in,
  input  wire logic              in_last_in,
  input  wire pa_pkg::pa_mode_t  mode_in,
  input  wire logic              gs_active_in,
  input  wire logic              cfg_valid_in,
  input  wire logic [15:0]       cfg_pname_in,
  input  wire logic [31:0]       cfg_value_in,
  output logic [7:0]             patch_size_out,
  output logic                   err_enum_out,
  output logic                   err_value_out,
  output logic                   out_valid_out,
  input  wire logic              out_ready_in,
  output logic [VW-1:0]          out_vtx_out,
  output logic                   out_prim_first_out,
  output logic                   out_prim_last_out,
  output logic                   out_adj_out
);
  localparam int HD  = (MAX_PATCH > pa_pkg::PA_HIST_MIN) ? MAX_PATCH : pa_pkg::PA_HIST_MIN;
  localparam int HIW = $clog2(HD);
  localparam int PW  = VW + 3;
  localparam logic [31:0] MAX_PATCH_W = MAX_PATCH;

  // ==========================================================================
  // Decode functions
  function automatic logic [7:0] grp_mod(input pa_pkg::pa_mode_t m, input logic [7:0] v);
    case (m)
      pa_pkg::PA_LINES:     grp_mod = 8'h02;
      pa_pkg::PA_TRIS:      grp_mod = 8'h03;
      pa_pkg::PA_LINES_ADJ: grp_mod = 8'h04;
      pa_pkg::PA_TRIS_ADJ:  grp_mod = 8'h06;
      pa_pkg::PA_PATCHES:   grp_mod = v;
      default:              grp_mod = 8'h01;
    endcase
  endfunction : grp_mod

  function automatic logic [7:0] prim_len(input pa_pkg::pa_mode_t m, input logic gs,
                                          input logic end_ph, input logic [3:0] cnt,
                                          input logic grp_end, input logic [7:0] v,
                                          input logic first);
    logic [7:0] n2;
    logic [7:0] n3;
    n2 = gs ? 8'h04 : 8'h02;
    n3 = gs ? 8'h06 : 8'h03;
    prim_len = 8'h00;
    if (end_ph) begin
      case (m)
        pa_pkg::PA_LINE_LOOP:  prim_len = (cnt >= 4'h2) ? 8'h02 : 8'h00;
        pa_pkg::PA_TSTRIP_ADJ: prim_len = (cnt >= 4'h6) ? n3 : 8'h00;
        default:               prim_len = 8'h00;
      endcase
    end else begin
      case (m)
        pa_pkg::PA_POINTS:     prim_len = 8'h01;
        pa_pkg::PA_LINE_STRIP,
        pa_pkg::PA_LINE_LOOP:  prim_len = first ? 8'h00 : 8'h02;
        pa_pkg::PA_LINES:      prim_len = grp_end ? 8'h02 : 8'h00;
        pa_pkg::PA_TRI_STRIP,
        pa_pkg::PA_TRI_FAN:    prim_len = (cnt >= 4'h3) ? 8'h03 : 8'h00;
        pa_pkg::PA_TRIS:       prim_len = grp_end ? 8'h03 : 8'h00;
        pa_pkg::PA_LINES_ADJ:  prim_len = grp_end ? n2 : 8'h00;
        pa_pkg::PA_LSTRIP_ADJ: prim_len = (cnt >= 4'h4) ? n2 : 8'h00;
        pa_pkg::PA_TRIS_ADJ:   prim_len = grp_end ? n3 : 8'h00;
        pa_pkg::PA_TSTRIP_ADJ: prim_len = (cnt >= 4'h8 && !cnt[0]) ? n3 : 8'h00;
        pa_pkg::PA_PATCHES:    prim_len = grp_end ? v : 8'h00;
        default:               prim_len = 8'h00;
      endcase
    end
  endfunction : prim_len

  // Ages count back from the current vertex (age 0)
  function automatic logic [7:0] pick_src(input pa_pkg::pa_mode_t m, input logic gs,
                                          input logic end_ph, input logic [7:0] k,
                                          input logic [3:0] cnt, input logic [7:0] v);
    logic [7:0] p [3];
    logic [7:0] a [3];
    logic [7:0] off;
    p   = '{8'h05, 8'h03, 8'h01};
    a   = '{8'h04, 8'h02, 8'h00};
    off = 8'h00;
    pick_src = 8'h00;
    if (m == pa_pkg::PA_TSTRIP_ADJ) begin
      if (end_ph) begin
        off = {7'h00, cnt[0]};
        if (cnt < 4'h8) begin
          a = '{8'h04, 8'h00, 8'h02};
        end else if (!cnt[1]) begin
          p = '{8'h03, 8'h05, 8'h01};
          a = '{8'h07, 8'h02, 8'h00};
        end else begin
          a = '{8'h07, 8'h00, 8'h02};
        end
      end else if (cnt == 4'h8) begin
        p = '{8'h07, 8'h05, 8'h03};
        a = '{8'h06, 8'h01, 8'h04};
      end else if (cnt[1]) begin
        p = '{8'h05, 8'h07, 8'h03};
        a = '{8'h09, 8'h04, 8'h01};
      end else begin
        p = '{8'h07, 8'h05, 8'h03};
        a = '{8'h09, 8'h01, 8'h04};
      end
    end
    case (m)
      pa_pkg::PA_LINE_STRIP: pick_src = (k == 8'h00) ? pa_pkg::PA_SRC_PREV : 8'h00;
      pa_pkg::PA_LINE_LOOP: begin
        if (end_ph) begin
          pick_src = (k == 8'h00) ? 8'h00 : pa_pkg::PA_SRC_FIRST;
        end else begin
          pick_src = (k == 8'h00) ? pa_pkg::PA_SRC_PREV : 8'h00;
        end
      end
      pa_pkg::PA_LINES:      pick_src = (k == 8'h00) ? pa_pkg::PA_SRC_A : 8'h00;
      pa_pkg::PA_TRI_STRIP,
      pa_pkg::PA_TRI_FAN: begin
        pick_src = (k == 8'h00) ? pa_pkg::PA_SRC_A :
                   (k == 8'h01) ? pa_pkg::PA_SRC_B : 8'h00;
      end
      pa_pkg::PA_TRIS:       pick_src = 8'h02 - k;
      pa_pkg::PA_LINES_ADJ,
      pa_pkg::PA_LSTRIP_ADJ: pick_src = (gs ? 8'h03 : 8'h02) - k;
      pa_pkg::PA_TRIS_ADJ,
      pa_pkg::PA_TSTRIP_ADJ: begin
        if (gs) begin
          pick_src = off + (k[0] ? a[k[2:1]] : p[k[2:1]]);
        end else begin
          pick_src = off + p[k[1:0]];
        end
      end
      pa_pkg::PA_PATCHES:    pick_src = v - 8'h01 - k;
      default:               pick_src = 8'h00;
    endcase
  endfunction : pick_src

  function automatic logic is_adj(input pa_pkg::pa_mode_t m, input logic gs,
                                  input logic [7:0] k);
    case (m)
      pa_pkg::PA_LINES_ADJ,
      pa_pkg::PA_LSTRIP_ADJ: is_adj = gs && (k == 8'h00 || k == 8'h03);
      pa_pkg::PA_TRIS_ADJ,
      pa_pkg::PA_TSTRIP_ADJ: is_adj = gs && k[0];
      default:               is_adj = 1'b0;
    endcase
  endfunction : is_adj

  // ==========================================================================
  // State
  pa_pkg::pa_state_t state_reg;
  pa_pkg::pa_state_t state_next;
  pa_pkg::pa_mode_t  mode_reg;
  logic              gs_reg;
  logic [7:0]        v_reg;
  logic [7:0]        patch_v_reg;
  logic [3:0]        cnt_reg;
  logic [7:0]        grp_reg;
  logic              last_reg;
  logic              first_flag_reg;
  logic              ptr_reg;
  logic [7:0]        k_reg;
  logic [VW-1:0]     hist_reg [HD];
  logic [VW-1:0]     a_reg;
  logic [VW-1:0]     a_next;
  logic [VW-1:0]     b_reg;
  logic [VW-1:0]     b_next;
  logic [VW-1:0]     prev_reg;
  logic [VW-1:0]     first_vtx_reg;
  logic              err_enum_reg;
  logic              err_value_reg;

  pa_stream_if #(.W(PW)) core_s ();
  pa_stream_if #(.W(PW)) out_s ();

  // ==========================================================================
  // Decode and selection
  wire             accept    = in_valid_in && (state_reg == pa_pkg::PA_ST_IDLE);
  wire             busy      = (state_reg != pa_pkg::PA_ST_IDLE);
  wire             end_ph    = (state_reg == pa_pkg::PA_ST_END);
  wire [7:0]       gmod      = grp_mod(mode_reg, v_reg);
  wire             grp_end   = (grp_reg == gmod - 8'h01);
  wire [7:0]       plen      = prim_len(mode_reg, gs_reg, end_ph, cnt_reg, grp_end,
                                        v_reg, first_flag_reg);
  wire [7:0]       src       = pick_src(mode_reg, gs_reg, end_ph, k_reg, cnt_reg, v_reg);
  wire             emitting  = busy && (k_reg < plen);
  wire             phase_end = busy && (k_reg >= plen);
  wire             upd       = (state_reg == pa_pkg::PA_ST_MAIN) && phase_end;
  wire             push      = emitting && core_s.ready;
  wire [VW-1:0]    cur       = hist_reg[0];
  wire [3:0]       cnt_inc   = (cnt_reg == pa_pkg::PA_CNT_HI) ? pa_pkg::PA_CNT_LO
                                                               : cnt_reg + 4'h1;
  wire [VW-1:0]    src_vtx   = (src == pa_pkg::PA_SRC_A)     ? a_reg :
                               (src == pa_pkg::PA_SRC_B)     ? b_reg :
                               (src == pa_pkg::PA_SRC_PREV)  ? prev_reg :
                               (src == pa_pkg::PA_SRC_FIRST) ? first_vtx_reg :
                               hist_reg[src[HIW-1:0]];
  wire signed [31:0] cfg_sval  = $signed(cfg_value_in);
  wire             cfg_name_ok = (cfg_pname_in == pa_pkg::PA_PNAME_PATCH_VTX);
  wire             cfg_val_ok  = (cfg_sval > 0) && (cfg_value_in <= MAX_PATCH_W);

  assign in_ready_out   = !busy;
  assign core_s.valid   = emitting;
  assign core_s.data    = {src_vtx, (k_reg == 8'h00), (k_reg == plen - 8'h01),
                           is_adj(mode_reg, gs_reg, k_reg)};
  assign out_s.ready    = out_ready_in;
  assign out_valid_out  = out_s.valid;
  assign out_vtx_out    = out_s.data[PW-1:3];
  assign out_prim_first_out = out_s.data[2];
  assign out_prim_last_out  = out_s.data[1];
  assign out_adj_out    = out_s.data[0];
  assign patch_size_out = patch_v_reg;
  assign err_enum_out   = err_enum_reg;
  assign err_value_out  = err_value_reg;

  // Stored-vertex updates once the vertex's own primitive has gone out
  always_comb begin
    a_next = a_reg;
    b_next = b_reg;
    case (mode_reg)
      pa_pkg::PA_TRI_STRIP: begin
        if (ptr_reg) begin
          b_next = cur;
        end else begin
          a_next = cur;
        end
      end
      pa_pkg::PA_TRI_FAN: begin
        if (first_flag_reg) begin
          a_next = cur;
        end else begin
          b_next = cur;
        end
      end
      pa_pkg::PA_LINES: begin
        if (grp_reg == 8'h00) begin
          a_next = cur;
        end
      end
      default: begin
        a_next = a_reg;
      end
    endcase
  end

  always_comb begin
    case (state_reg)
      pa_pkg::PA_ST_IDLE: state_next = accept ? pa_pkg::PA_ST_MAIN : pa_pkg::PA_ST_IDLE;
      pa_pkg::PA_ST_MAIN: begin
        if (!phase_end) begin
          state_next = pa_pkg::PA_ST_MAIN;
        end else begin
          state_next = last_reg ? pa_pkg::PA_ST_END : pa_pkg::PA_ST_IDLE;
        end
      end
      pa_pkg::PA_ST_END:  state_next = phase_end ? pa_pkg::PA_ST_IDLE : pa_pkg::PA_ST_END;
      default:            state_next = pa_pkg::PA_ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Vertex history, shifted on every accepted vertex
  always_ff @(posedge ref_clk_in) begin
    if (accept) begin
      hist_reg[0] <= in_vtx_in;
    end
  end

  for (genvar i = 1; i < HD; i++) begin : g_hist
    always_ff @(posedge ref_clk_in) begin
      if (accept) begin
        hist_reg[i] <= hist_reg[i-1];
      end
    end
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_reg <= pa_pkg::PA_ST_IDLE;
      k_reg     <= 8'h00;
    end else begin
      state_reg <= state_next;
      k_reg     <= phase_end ? 8'h00 : (push ? k_reg + 8'h01 : k_reg);
    end
  end

  // Draw-wide settings latched on the first vertex; count and last flag on every vertex
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_reg <= pa_pkg::PA_POINTS;
      gs_reg   <= 1'b0;
      v_reg    <= pa_pkg::PA_PATCH_RESET;
      cnt_reg  <= 4'h0;
      last_reg <= 1'b0;
    end else if (accept) begin
      if (in_first_in) begin
        mode_reg <= mode_in;
        gs_reg   <= gs_active_in;
        v_reg    <= patch_v_reg;
      end
      cnt_reg  <= in_first_in ? 4'h1 : cnt_inc;
      last_reg <= in_last_in;
    end
  end

  // Per-vertex assembly state
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      grp_reg        <= 8'h00;
      first_flag_reg <= 1'b1;
      ptr_reg        <= 1'b0;
    end else if (accept && in_first_in) begin
      grp_reg        <= 8'h00;
      first_flag_reg <= 1'b1;
      ptr_reg        <= 1'b0;
    end else if (upd) begin
      grp_reg        <= grp_end ? 8'h00 : grp_reg + 8'h01;
      first_flag_reg <= 1'b0;
      ptr_reg        <= ~ptr_reg;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (upd) begin
      a_reg    <= a_next;
      b_reg    <= b_next;
      prev_reg <= cur;
      if (first_flag_reg) begin
        first_vtx_reg <= cur;
      end
    end
  end

  // ==========================================================================
  // Patch-size setting; a rejected write leaves the old value standing
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      patch_v_reg   <= pa_pkg::PA_PATCH_RESET;
      err_enum_reg  <= 1'b0;
      err_value_reg <= 1'b0;
    end else begin
      err_enum_reg  <= cfg_valid_in && !cfg_name_ok;
      err_value_reg <= cfg_valid_in && cfg_name_ok && !cfg_val_ok;
      if (cfg_valid_in && cfg_name_ok && cfg_val_ok) begin
        patch_v_reg <= cfg_value_in[7:0];
      end
    end
  end

  // ==========================================================================
  // Output buffer: downstream stalls back-pressure the sequencer
  pa_pair_buf #(.W(PW)) u_buf (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .enq        (core_s),
    .deq        (out_s)
  );

endmodule : pa_assembler

// *** rtl/pa_pair_buf.sv ***
// Two-entry buffer on the assembled vertex stream
`timescale 1ns/1ps
module pa_pair_buf #(
  parameter int W = 8
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  pa_stream_if.snk  enq,
  pa_stream_if.src  deq
);
  logic [W-1:0] mem_reg [2];
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   count_reg;

  wire push = enq.valid && enq.ready;
  wire pop  = deq.valid && deq.ready;

  assign enq.ready = (count_reg != 2'h2);
  assign deq.valid = (count_reg != 2'h0);
  assign deq.data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= enq.data;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg  <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : pa_pair_buf

// *** rtl/pa_pkg.sv ***
// Shared constants and types of the primitive assembler
package pa_pkg;

  // ==========================================================================
  // Primitive modes and sequencer states
  typedef enum logic [3:0] {
    PA_POINTS     = 4'h0,
    PA_LINE_STRIP = 4'h1,
    PA_LINE_LOOP  = 4'h2,
    PA_LINES      = 4'h3,
    PA_TRI_STRIP  = 4'h4,
    PA_TRI_FAN    = 4'h5,
    PA_TRIS       = 4'h6,
    PA_LINES_ADJ  = 4'h7,
    PA_LSTRIP_ADJ = 4'h8,
    PA_TRIS_ADJ   = 4'h9,
    PA_TSTRIP_ADJ = 4'hA,
    PA_PATCHES    = 4'hB
  } pa_mode_t;

  typedef enum logic [1:0] {
    PA_ST_IDLE = 2'h0,
    PA_ST_MAIN = 2'h1,
    PA_ST_END  = 2'h2
  } pa_state_t;

  // ==========================================================================
  // Vertex source codes: below PA_SRC_A a code is an age in the history
  localparam logic [7:0] PA_SRC_A     = 8'hF0;
  localparam logic [7:0] PA_SRC_B     = 8'hF1;
  localparam logic [7:0] PA_SRC_PREV  = 8'hF2;
  localparam logic [7:0] PA_SRC_FIRST = 8'hF3;

  // ==========================================================================
  // Configuration
  localparam logic [7:0]  PA_PATCH_RESET     = 8'h03;
  localparam logic [15:0] PA_PNAME_PATCH_VTX = 16'h0001;
  localparam int          PA_MAX_PATCH_DEF   = 32;
  localparam int          PA_HIST_MIN        = 10;

  // Vertex count wraps from the high mark back to the low mark; bits 1:0 agree
  localparam logic [3:0] PA_CNT_HI = 4'hD;
  localparam logic [3:0] PA_CNT_LO = 4'hA;

endpackage : pa_pkg

// *** rtl/pa_stream_if.sv ***
// Valid/ready stream carrier between assembler modules
`timescale 1ns/1ps
interface pa_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : pa_stream_if
